/* supply_monitor_pkg.sv */
package supply_monitor_pkg;

   // Bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LANE_W = 4;
   localparam int BYTE_W = 8;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_INTEN_CLR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_INTEN_SET = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_INTFLAG   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h10;

   // Flag, enable and status layout.
   localparam int FLAG_W             = 6;
   localparam int POS_IO_READY       = 0;
   localparam int POS_IO_DETECT      = 1;
   localparam int POS_IO_SYNC_READY  = 2;
   localparam int POS_CORE_READY     = 3;
   localparam int POS_CORE_DETECT    = 4;
   localparam int POS_CORE_SYNC_RDY  = 5;

   // Control register layout.
   localparam int CTRL_W             = 4;
   localparam int POS_CTRL_CORE_EN   = 0;
   localparam int POS_CTRL_IO_EN     = 1;
   localparam int POS_CTRL_PIN_A     = 2;
   localparam int POS_CTRL_PIN_B     = 3;

   // Reset values.
   localparam logic [FLAG_W-1:0] RST_FLAG  = 6'h00;
   localparam logic [FLAG_W-1:0] RST_INTEN = 6'h00;
   localparam logic [CTRL_W-1:0] RST_CTRL  = 4'h0;
   localparam logic [DATA_W-1:0] RST_RDATA = 32'h00000000;

   // Synchroniser depth for monitor status inputs.
   localparam int SYNC_STAGES = 3;

endpackage : supply_monitor_pkg

/* supply_monitor_irq_flags.sv */
`timescale 1ns/1ps

module supply_monitor_irq_flags (
   // Clock and reset.
   input  wire  logic                                 sys_clk,
   input  wire  logic                                 rst_n,
   // Register bus.
   input  wire  logic [supply_monitor_pkg::ADDR_W-1:0] bus_addr,
   input  wire  logic [supply_monitor_pkg::DATA_W-1:0] bus_wdata,
   input  wire  logic [supply_monitor_pkg::LANE_W-1:0] bus_byte_en,
   input  wire  logic                                 bus_write,
   input  wire  logic                                 bus_read,
   output       logic [supply_monitor_pkg::DATA_W-1:0] bus_rdata,
   // Peripheral access guard.
   input  wire  logic                                 write_protect,
   // Monitor status, asynchronous to sys_clk.
   input  wire  logic [supply_monitor_pkg::FLAG_W-1:0] mon_status_raw,
   // Nonvolatile user row setting.
   input  wire  logic                                 user_row_core_mon_en,
   // Real-time counter pin claims.
   input  wire  logic                                 rtc_pin_a_drive,
   input  wire  logic                                 rtc_pin_a_level,
   input  wire  logic                                 rtc_pin_b_drive,
   input  wire  logic                                 rtc_pin_b_level,
   // Monitor enables.
   output       logic                                 core_brownout_monitor,
   output       logic                                 io_brownout_monitor,
   // Supply output pins.
   output       logic                                 supply_output_pin_a,
   output       logic                                 supply_output_pin_b,
   // Interrupt request.
   output       logic                                 irq
);

   import supply_monitor_pkg::*;

   // Flag, enable and control state; boot_loaded_ff is low only in the
   // first cycle after reset, while the user row setting is taken.
   logic [FLAG_W-1:0] flag_ff;
   logic [FLAG_W-1:0] nxt_flag;
   logic [FLAG_W-1:0] inten_ff;
   logic [FLAG_W-1:0] nxt_inten;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [CTRL_W-1:0] nxt_ctrl;
   logic              boot_loaded_ff;

   // Output flip-flops; every output of the block comes from one of these
   // or straight from a register process further down.
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic              irq_ff;
   logic              pin_a_ff;
   logic              pin_b_ff;

   // Synchronised status and its rising edges, driven bit by bit from the
   // generate loop below.
   wire  logic [FLAG_W-1:0] status_stable;
   wire  logic [FLAG_W-1:0] status_rise;

   // Bus decode; all of it is combinational and settles within the cycle
   // in which a strobe stands.
   logic [DATA_W-1:0] lane_bits;
   logic [DATA_W-1:0] wr_ones;
   logic              hit_inten_clr;
   logic              hit_inten_set;
   logic              hit_intflag;
   logic              hit_status;
   logic              hit_ctrl;
   logic              protectable;
   logic              wr_accept;
   logic [FLAG_W-1:0] flag_clear;
   logic [FLAG_W-1:0] inten_clear;
   logic [FLAG_W-1:0] inten_set;
   logic [CTRL_W-1:0] ctrl_lane;

   // Expands byte enables into a bit mask over the data word; lane i
   // covers data bits 8i+7 down to 8i.
   function automatic logic [DATA_W-1:0] lane_mask(
      input logic [LANE_W-1:0] be
   );
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < LANE_W; i++) begin
         m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
      end
      return m;
   endfunction : lane_mask

   // Core enable for this edge: the user row during the boot load, else the current control bit.
   // Taking the next value lets the enable appear one edge after release
   // of reset, together with the control bit that the boot load writes.
   function automatic logic nxt_ctrl_core_en();
      return boot_loaded_ff ? ctrl_ff[POS_CTRL_CORE_EN]
                            : user_row_core_mon_en;
   endfunction : nxt_ctrl_core_en

   // Per-bit three-stage synchroniser with agreement filter and edge detect.
   // The monitor status bits change on their own timing; a bit that flips
   // for a single cycle never makes the last two stages agree on it.
   genvar gi;
   for (gi = 0; gi < FLAG_W; gi++) begin : g_status
      // Three retiming stages and the last agreed level of this bit.
      logic sy1_ff;
      logic sy2_ff;
      logic sy3_ff;
      logic level_ff;

      // The first stage feeds only the second stage.
      // It may still be settling, so nothing else looks at it.
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            sy1_ff <= 1'b0;
            sy2_ff <= 1'b0;
            sy3_ff <= 1'b0;
         end else begin
            sy1_ff <= mon_status_raw[gi];
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
         end
      end

      // A new level is accepted once the second and third stages agree.
      // Holding the agreed level keeps a bounce from counting twice.
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            level_ff <= 1'b0;
         end else if (sy2_ff == sy3_ff) begin
            level_ff <= sy3_ff;
         end
      end

      // A zero-to-one change of the accepted level is one set event.
      // It stands for one cycle, the cycle in which the level is taken.
      assign status_rise[gi]   = (sy2_ff == sy3_ff) & sy3_ff & ~level_ff;
      assign status_stable[gi] = level_ff;
   end

   // Address decode of the register bus.
   // Addresses are matched in full, so each register has one offset.
   // Sub-word accesses use the word offset and pick lanes by enables.
   always_comb begin
      hit_inten_clr = (bus_addr == OFS_INTEN_CLR);
      hit_inten_set = (bus_addr == OFS_INTEN_SET);
      hit_intflag   = (bus_addr == OFS_INTFLAG);
      hit_status    = (bus_addr == OFS_STATUS);
      hit_ctrl      = (bus_addr == OFS_CTRL);
   end

   // Enable and control registers are protectable; flags are not.
   // The flags stay open so that a handler can always acknowledge an
   // interrupt, even while the guard locks the configuration.
   always_comb begin
      protectable = hit_inten_clr | hit_inten_set | hit_ctrl;
      wr_accept   = bus_write & ~(protectable & write_protect);
   end

   // Only the byte lanes that the access names carry ones.
   // A write that leaves out lane 0 therefore changes no field.
   always_comb begin
      lane_bits = lane_mask(bus_byte_en);
      wr_ones   = bus_wdata & lane_bits;
   end

   // Per-register write effects.
   // Writes to the status address or an unmapped address do nothing.
   always_comb begin
      flag_clear  = '0;
      inten_clear = '0;
      inten_set   = '0;
      if (wr_accept && hit_intflag) begin
         flag_clear = wr_ones[FLAG_W-1:0];
      end
      if (wr_accept && hit_inten_clr) begin
         inten_clear = wr_ones[FLAG_W-1:0];
      end
      if (wr_accept && hit_inten_set) begin
         inten_set = wr_ones[FLAG_W-1:0];
      end
   end

   // Flag next value: set events win over software clears.
   // Without this an edge arriving in the cycle of a clear would vanish,
   // and the interrupt that it stands for would never be raised.
   always_comb begin
      nxt_flag = (flag_ff & ~flag_clear) | status_rise;
   end

   // Sticky flags, one per monitor status bit.
   // Each position is written on its own line for traceability.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= RST_FLAG;
      end else begin
         flag_ff[POS_CORE_SYNC_RDY] <= nxt_flag[POS_CORE_SYNC_RDY];
         flag_ff[POS_CORE_DETECT]   <= nxt_flag[POS_CORE_DETECT];
         flag_ff[POS_CORE_READY]    <= nxt_flag[POS_CORE_READY];
         flag_ff[POS_IO_SYNC_READY] <= nxt_flag[POS_IO_SYNC_READY];
         flag_ff[POS_IO_DETECT]     <= nxt_flag[POS_IO_DETECT];
         flag_ff[POS_IO_READY]      <= nxt_flag[POS_IO_READY];
      end
   end

   // Interrupt enables, set and cleared through separate addresses.
   // Set and clear use different addresses, so they never meet.
   always_comb begin
      nxt_inten = (inten_ff | inten_set) & ~inten_clear;
   end

   // Enable register.
   // Both enable addresses read back these same bits.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         inten_ff <= RST_INTEN;
      end else begin
         inten_ff <= nxt_inten;
      end
   end

   // Control bits that a write may change, lanes taken into account.
   // Lanes that the access leaves out keep their old bits.
   always_comb begin
      ctrl_lane = lane_bits[CTRL_W-1:0];
      nxt_ctrl  = ctrl_ff;
      if (wr_accept && hit_ctrl) begin
         nxt_ctrl = (ctrl_ff & ~ctrl_lane)
                  | (bus_wdata[CTRL_W-1:0] & ctrl_lane);
      end
   end

   // Marks that the user row setting has been taken after reset.
   // The user row is thus applied once per reset, and software may
   // override it from then on.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_loaded_ff <= 1'b0;
      end else begin
         boot_loaded_ff <= 1'b1;
      end
   end

   // Control register; the first edge after reset loads the user row.
   // A software write in that first cycle loses to the boot load.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= RST_CTRL;
      end else if (!boot_loaded_ff) begin
         ctrl_ff                   <= RST_CTRL;
         ctrl_ff[POS_CTRL_CORE_EN] <= user_row_core_mon_en;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // Monitor enables follow the control register.
   // The core enable takes the user row at boot, then follows its control bit one edge later; see nxt_ctrl_core_en.
   // The I/O enable follows its control bit one edge later.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_brownout_monitor <= 1'b0;
         io_brownout_monitor   <= 1'b0;
      end else begin
         core_brownout_monitor <= nxt_ctrl_core_en();
         io_brownout_monitor   <= ctrl_ff[POS_CTRL_IO_EN];
      end
   end

   // Output pins; the counter's claim overrides the control bit.
   // The claim is a level on this clock and needs no synchroniser; a
   // dropped claim hands the pin back to the control bit at the next edge.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_a_ff <= 1'b0;
         pin_b_ff <= 1'b0;
      end else begin
         pin_a_ff <= rtc_pin_a_drive ? rtc_pin_a_level
                                     : ctrl_ff[POS_CTRL_PIN_A];
         pin_b_ff <= rtc_pin_b_drive ? rtc_pin_b_level
                                     : ctrl_ff[POS_CTRL_PIN_B];
      end
   end

   // Interrupt request from flags gated by their enables.
   // It is built from the next flag and enable values, so it changes on
   // the same edge as the flag or enable that causes the change.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_flag & nxt_inten);
      end
   end

   // Read data selection; unmapped addresses read as zero.
   // Byte enables are ignored on reads: the whole word is returned and a
   // narrow access takes its own lanes from it.
   always_comb begin
      nxt_rdata = RST_RDATA;
      if (bus_read) begin
         if (hit_inten_clr || hit_inten_set) begin
            nxt_rdata[FLAG_W-1:0] = inten_ff;
         end else if (hit_intflag) begin
            nxt_rdata[FLAG_W-1:0] = flag_ff;
         end else if (hit_status) begin
            nxt_rdata[FLAG_W-1:0] = status_stable;
         end else if (hit_ctrl) begin
            nxt_rdata[CTRL_W-1:0] = ctrl_ff;
         end
      end
   end

   // Read data stands for exactly the cycle after the read strobe.
   // Showing zero at all other times keeps stale data off the bus.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= RST_RDATA;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Outputs come straight from flip-flops.
   // No logic sits between these registers and the pins of the block.
   assign bus_rdata           = rdata_ff;
   assign irq                 = irq_ff;
   assign supply_output_pin_a = pin_a_ff;
   assign supply_output_pin_b = pin_b_ff;

endmodule : supply_monitor_irq_flags

/* supply_monitor_irq_flags_asserts.sv */
`timescale 1ns/1ps

module supply_monitor_irq_flags_asserts (
   // Clock and reset.
   input wire logic                                    sys_clk,
   input wire logic                                    rst_n,
   // Register bus.
   input wire logic [supply_monitor_pkg::ADDR_W-1:0]   bus_addr,
   input wire logic [supply_monitor_pkg::DATA_W-1:0]   bus_wdata,
   input wire logic [supply_monitor_pkg::LANE_W-1:0]   bus_byte_en,
   input wire logic                                    bus_write,
   input wire logic                                    bus_read,
   input wire logic [supply_monitor_pkg::DATA_W-1:0]   bus_rdata,
   // Inputs that steer the watched outputs.
   input wire logic                                    write_protect,
   input wire logic [supply_monitor_pkg::FLAG_W-1:0]   mon_status_raw,
   input wire logic                                    user_row_core_mon_en,
   input wire logic                                    rtc_pin_a_drive,
   input wire logic                                    rtc_pin_a_level,
   input wire logic                                    rtc_pin_b_drive,
   input wire logic                                    rtc_pin_b_level,
   // Watched outputs.
   input wire logic                                    core_brownout_monitor,
   input wire logic                                    io_brownout_monitor,
   input wire logic                                    supply_output_pin_a,
   input wire logic                                    supply_output_pin_b,
   input wire logic                                    irq
);
   import supply_monitor_pkg::*;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // A write that reaches lane 0, where every field lives.
   wire logic wr_lane0 = bus_write && bus_byte_en[0];

   // Read data stand one cycle only, otherwise the bus shows zero.
   chk_rdata_idle: assert property (
      !$past(bus_read) |-> bus_rdata == RST_RDATA)
      else $error("read data seen outside the answer cycle");
   // A counter claim decides the pin level one edge later.
   chk_pin_a_claim: assert property (
      $past(rst_n) && $past(rtc_pin_a_drive)
      |-> supply_output_pin_a == $past(rtc_pin_a_level))
      else $error("pin a ignores the counter claim");
   chk_pin_b_claim: assert property (
      $past(rst_n) && $past(rtc_pin_b_drive)
      |-> supply_output_pin_b == $past(rtc_pin_b_level))
      else $error("pin b ignores the counter claim");
   // The interrupt only drops by a flag clear or an enable clear.
   chk_irq_fall_cause: assert property (
      $fell(irq) |-> $past(wr_lane0) && ($past(bus_addr) == OFS_INTFLAG
      || $past(bus_addr) == OFS_INTEN_CLR))
      else $error("interrupt fell with no clearing write");
   // Clearing every flag while status is quiet leaves no request.
   chk_clear_all: assert property (
      $stable(mon_status_raw) [*6] ##0 (wr_lane0
      && bus_addr == OFS_INTFLAG && bus_wdata[5:0] == 6'h3F) |=> !irq)
      else $error("interrupt stays after all flags cleared");
   chk_mask_all: assert property (
      wr_lane0 && !write_protect && bus_addr == OFS_INTEN_CLR
      && bus_wdata[5:0] == 6'h3F |=> !irq)
      else $error("interrupt stays with every enable cleared");
   // An open control write drives the I/O monitor enable.
   chk_ctrl_io: assert property (
      $past(rst_n) && wr_lane0 && !write_protect && bus_addr == OFS_CTRL
      |=> ##1 io_brownout_monitor == $past(bus_wdata[POS_CTRL_IO_EN], 2))
      else $error("I/O monitor enable misses the control write");
   chk_ctrl_guard: assert property (
      !bus_write ##1 (wr_lane0 && write_protect && bus_addr == OFS_CTRL)
      ##1 !bus_write |=> $stable(io_brownout_monitor))
      else $error("guarded control write took effect");
   // The user row decides the core monitor enable at boot.
   chk_core_boot: assert property (
      $rose(rst_n) |=> core_brownout_monitor == $past(user_row_core_mon_en))
      else $error("core monitor enable not loaded at boot");

endmodule : supply_monitor_irq_flags_asserts

bind supply_monitor_irq_flags supply_monitor_irq_flags_asserts
   supply_monitor_irq_flags_asserts_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_byte_en(bus_byte_en), .bus_write(bus_write),
   .bus_read(bus_read), .bus_rdata(bus_rdata),
   .write_protect(write_protect), .mon_status_raw(mon_status_raw),
   .user_row_core_mon_en(user_row_core_mon_en),
   .rtc_pin_a_drive(rtc_pin_a_drive), .rtc_pin_a_level(rtc_pin_a_level),
   .rtc_pin_b_drive(rtc_pin_b_drive), .rtc_pin_b_level(rtc_pin_b_level),
   .core_brownout_monitor(core_brownout_monitor),
   .io_brownout_monitor(io_brownout_monitor),
   .supply_output_pin_a(supply_output_pin_a),
   .supply_output_pin_b(supply_output_pin_b), .irq(irq));

/* tb_top.sv */
`timescale 1ns/1ps

module tb_top;
   import supply_monitor_pkg::*;

   logic              sys_clk, rst_n, bus_write, bus_read, write_protect;
   logic              user_row_core_mon_en, rtc_pin_a_drive, rtc_pin_a_level;
   logic              rtc_pin_b_drive, rtc_pin_b_level, irq;
   logic              core_brownout_monitor, io_brownout_monitor;
   logic              supply_output_pin_a, supply_output_pin_b;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_wdata, bus_rdata;
   logic [LANE_W-1:0] bus_byte_en;
   logic [FLAG_W-1:0] mon_status_raw;
   int                fails, num_checks;

   supply_monitor_irq_flags supply_monitor_irq_flags_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_byte_en(bus_byte_en),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
      .write_protect(write_protect), .mon_status_raw(mon_status_raw),
      .user_row_core_mon_en(user_row_core_mon_en),
      .rtc_pin_a_drive(rtc_pin_a_drive), .rtc_pin_a_level(rtc_pin_a_level),
      .rtc_pin_b_drive(rtc_pin_b_drive), .rtc_pin_b_level(rtc_pin_b_level),
      .core_brownout_monitor(core_brownout_monitor),
      .io_brownout_monitor(io_brownout_monitor),
      .supply_output_pin_a(supply_output_pin_a),
      .supply_output_pin_b(supply_output_pin_b), .irq(irq));

   // The 40 MHz system clock.
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One write cycle, then an idle cycle so strobes never touch.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      bus_addr    <= a;
      bus_wdata   <= d;
      bus_byte_en <= be;
      bus_write   <= 1'b1;
      tick(1);
      bus_write <= 1'b0;
      tick(1);
   endtask : wr

   // One read cycle; data are taken mid-way through the answer cycle.
   task automatic rdchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
      bus_addr <= a;
      bus_read <= 1'b1;
      tick(1);
      bus_read <= 1'b0;
      @(negedge sys_clk);
      chk(what, exp, bus_rdata);
      tick(1);
   endtask : rdchk

   task automatic t_boot;
      tick(1);
      chk("core_mon", 32'h1, {31'h0, core_brownout_monitor});
      rdchk("ctrl", OFS_CTRL, 32'h1);
      rdchk("flags", OFS_INTFLAG, 32'h0);
      rdchk("unmapped", 8'h20, 32'h0);
   endtask : t_boot

   // Each flag position in turn: set, masked, enabled, kept, cleared.
   task automatic t_flags;
      logic [31:0] m;
      for (int i = 0; i < FLAG_W; i++) begin
         m = 32'h1 << i;
         mon_status_raw <= m[5:0];
         tick(6);
         rdchk("flag set", OFS_INTFLAG, m);
         rdchk("status", OFS_STATUS, m);
         chk("irq masked", 32'h0, {31'h0, irq});
         wr(OFS_INTEN_SET, m, 4'h1);
         chk("irq raised", 32'h1, {31'h0, irq});
         wr(OFS_INTFLAG, ~m, 4'hF);
         rdchk("flag kept", OFS_INTFLAG, m);
         wr(OFS_INTFLAG, m, 4'h1);
         chk("irq cleared", 32'h0, {31'h0, irq});
         rdchk("flag clear", OFS_INTFLAG, 32'h0);
         wr(OFS_INTEN_CLR, m, 4'h1);
         mon_status_raw <= 6'h00;
         tick(6);
      end
   endtask : t_flags

   // Guarded writes, a missing byte lane, the read-only status, pins.
   task automatic t_regs;
      write_protect <= 1'b1;
      wr(OFS_INTEN_SET, 32'h3F, 4'hF);
      wr(OFS_CTRL, 32'hE, 4'hF);
      rdchk("guard en", OFS_INTEN_SET, 32'h0);
      rdchk("guard ctrl", OFS_CTRL, 32'h1);
      write_protect <= 1'b0;
      wr(OFS_CTRL, 32'hE, 4'hE);
      rdchk("lane ctrl", OFS_CTRL, 32'h1);
      wr(OFS_STATUS, 32'h3F, 4'hF);
      rdchk("status ro", OFS_STATUS, 32'h0);
      wr(OFS_CTRL, 32'hE, 4'h1);
      tick(1);
      chk("io_mon", 32'h1, {31'h0, io_brownout_monitor});
      chk("core_mon", 32'h0, {31'h0, core_brownout_monitor});
      chk("pins", 32'h3, {30'h0, supply_output_pin_b,
                          supply_output_pin_a});
      rtc_pin_a_drive <= 1'b1;
      rtc_pin_b_drive <= 1'b1;
      rtc_pin_b_level <= 1'b1;
      tick(2);
      chk("claimed", 32'h2, {30'h0, supply_output_pin_b,
                             supply_output_pin_a});
      rtc_pin_a_drive <= 1'b0;
      rtc_pin_b_drive <= 1'b0;
   endtask : t_regs

   // A clear landing on the very edge where the flag sets must lose.
   task automatic t_race;
      wr(OFS_INTEN_SET, 32'h1, 4'h1);
      mon_status_raw <= 6'h01;
      tick(3);
      wr(OFS_INTFLAG, 32'h1, 4'h1);
      rdchk("race", OFS_INTFLAG, 32'h1);
      chk("race irq", 32'h1, {31'h0, irq});
      wr(OFS_INTEN_CLR, 32'h3F, 4'h1);
      chk("irq all masked", 32'h0, {31'h0, irq});
      wr(OFS_INTEN_SET, 32'h1, 4'h1);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(OFS_INTFLAG, 32'h3F, 4'h1);
      chk("irq all clear", 32'h0, {31'h0, irq});
      rdchk("race clear", OFS_INTFLAG, 32'h0);
      wr(OFS_INTEN_CLR, 32'h3F, 4'h1);
      mon_status_raw <= 6'h00;
   endtask : t_race

   // A second reset with the user row off clears all and boots cold.
   task automatic t_reboot;
      wr(OFS_INTEN_SET, 32'h3F, 4'h1);
      user_row_core_mon_en <= 1'b0;
      rst_n                <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(2);
      chk("core_mon off", 32'h0, {31'h0, core_brownout_monitor});
      chk("pins reset", 32'h0, {30'h0, supply_output_pin_b,
                                supply_output_pin_a});
      rdchk("boot ctrl", OFS_CTRL, 32'h0);
      rdchk("boot en", OFS_INTEN_SET, 32'h0);
   endtask : t_reboot

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // Reset, then the scenarios in turn.
   initial begin
      {bus_write, bus_read, write_protect, rst_n} = 4'h0;
      {rtc_pin_a_drive, rtc_pin_a_level} = 2'h0;
      {rtc_pin_b_drive, rtc_pin_b_level} = 2'h0;
      user_row_core_mon_en = 1'b1;
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      bus_byte_en = 4'h0;
      mon_status_raw = 6'h00;
      tick(6);
      rst_n <= 1'b1;
      tick(1);
      t_boot();
      t_flags();
      t_regs();
      t_race();
      t_reboot();
      conclude();
   end

   // A hang is cut short well beyond the expected run length.
   initial begin
      tick(20000);
      fails++;
      conclude();
   end

endmodule : tb_top
